// [rtl/dpa_pkg.sv]
package dpa_pkg;

  // ************************************************************
  // Port configuration codes
  // ************************************************************
  localparam logic [1:0] DPA_SEL_JTAG5 = 2'h0;   // Five-wire JTAG with test reset
  localparam logic [1:0] DPA_SEL_JTAG4 = 2'h1;   // Four-wire JTAG
  localparam logic [1:0] DPA_SEL_SWD = 2'h2;     // Serial wire debug
  localparam logic [1:0] DPA_SEL_OFF = 2'h3;     // Port disabled, pins GPIO until an acquire key selects SWD

  // ************************************************************
  // Acquire frame and changeover sequences
  // ************************************************************
  localparam logic [7:0] DPA_ACQ_REQ = 8'h99;     // Start,AP0,W,A2=1,A3=1,par=0,stop,park
  localparam logic [31:0] DPA_ACQ_KEY = 32'h7b0c06db; // Acquire key data word
  localparam logic [15:0] DPA_SEQ_TO_JTAG = 16'he73c; // Changeover value, LSB first
  localparam logic [15:0] DPA_SEQ_TO_SWD = 16'he79e;  // Changeover value, LSB first
  localparam int DPA_HIGH_RUN = 50;                   // High clocks before a changeover
  localparam logic [2:0] DPA_ACK_OK = 3'h1;           // SWD OK acknowledge, LSB first
  localparam int DPA_ACQ_BITS = 46;                   // Request, turn, ack, turn, data, parity
  localparam int DPA_EDGES_EXTEND = 8;                // Edges that extend the key window

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int DPA_CLK_MHZ = 40;                    // System clock rate
  localparam int DPA_WIN_SHORT_US = 8;                // Initial key window
  localparam int DPA_WIN_LONG_US = 400;               // Extended key window
  localparam int DPA_WIN_SHORT_CYC = DPA_WIN_SHORT_US * DPA_CLK_MHZ;
  localparam int DPA_WIN_LONG_CYC = DPA_WIN_LONG_US * DPA_CLK_MHZ;

  // ************************************************************
  // Debug control register layout
  // ************************************************************
  localparam int DPA_CTL_ACT = 0;                     // Activate bit
  localparam int DPA_CTL_HALT = 1;                    // Halt bit
  localparam int DPA_CTL_STEP = 2;                    // Step bit
  localparam logic [3:0] DPA_CTL_KEY = 4'hb;          // Key in bits 7:4
  localparam logic [7:0] DPA_CTL_RESET = 8'h00;       // Value after reset
  localparam int DPA_PERMIT_BIT = 0;                  // Permit bit in its register
  localparam logic [7:0] DPA_PERMIT_RESET = 8'h00;    // Value after reset

  // ************************************************************
  // Link states
  // ************************************************************
  typedef enum logic [2:0] {
    DPA_ST_GPIO = 3'b000,   // Pins idle as GPIO
    DPA_ST_KEYWIN = 3'b001, // Watching for acquire key
    DPA_ST_SWD = 3'b010,    // SWD owns the pins
    DPA_ST_JTAG = 3'b011    // JTAG owns the pins
  } dpa_state_t;

endpackage

// [rtl/dpa_seq_det.sv]
`timescale 1ns/100ps
`default_nettype none
// Watches one serial data line for a run of high bits then a 16-bit value.
module dpa_seq_det #(
  parameter int RUN = 50,
  parameter logic [15:0] PATTERN = 16'h0000
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_clear,
  input wire logic i_bit_en,
  input wire logic i_bit,
  output logic o_hit
);
  import dpa_pkg::*;

  logic [6:0] run_q, run_d;       // High bits seen in a row, saturating
  logic [15:0] shf_q, shf_d;      // Bits since the run ended
  logic [4:0] cnt_q, cnt_d;       // Count of collected bits
  logic armed_q, armed_d;         // Run is long enough
  logic hit_q, hit_d;             // One-cycle match pulse

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    run_d = run_q;
    shf_d = shf_q;
    cnt_d = cnt_q;
    armed_d = armed_q;
    hit_d = 1'b0;
    if (i_clear) begin
      run_d = '0;
      cnt_d = '0;
      armed_d = 1'b0;
    end else if (i_bit_en) begin
      // LSB arrives first, so shift in from the top
      if (armed_q && (cnt_q != 5'h0 || !i_bit)) begin
        shf_d = {i_bit, shf_q[15:1]};
        cnt_d = cnt_q + 5'h1;
        if (cnt_q == 5'hf) begin
          hit_d = ({i_bit, shf_q[15:1]} == PATTERN);
          armed_d = 1'b0;
          cnt_d = '0;
          run_d = '0;
        end
      end else begin
        // Still inside the run of high bits
        run_d = i_bit ? ((run_q == 7'h7f) ? run_q : run_q + 7'h1) : 7'h0;
        if (i_bit && run_q >= 7'(RUN - 1))
          armed_d = 1'b1;
      end
    end
  end

  // Registers
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      run_q <= '0;
      shf_q <= '0;
      cnt_q <= '0;
      armed_q <= 1'b0;
      hit_q <= 1'b0;
    end else if (i_ce) begin
      run_q <= run_d;
      shf_q <= shf_d;
      cnt_q <= cnt_d;
      armed_q <= armed_d;
      hit_q <= hit_d;
    end
  end

  assign o_hit = hit_q;
endmodule // dpa_seq_det
`default_nettype wire

// [rtl/dpa_port_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// R1 - Latch bits pick JTAG5, JTAG4, SWD, disabled
// R2 - Viewer output drives the TDO pin always; TDO is enabled only while SWD or JTAG owns the pins
// R3 - Disabled port: key only within 8 us
// R4 - Eight clock edges extend window to 400 us
// R5 - Key accepted on standard or alternate pair
// R6 - Key frame is write DP 11, fixed data
// R7 - Host repeats frame until OK acknowledge
// R8 - After acquire, SWD idles ready for writes
// R9 - SWD-to-JTAG only after standard-pair acquire; code also allows it when the latch selects SWD
// R10 - 50 high then 0xE73C gives JTAG4
// R11 - 50 high TMS then 0xE79E gives SWD
// R12 - Host acquires, changes to JTAG, then scans
// R13 - Latch-selected interface usable without acquisition
// R14 - Debug unit reachable only when permit set
// R15 - Debug registers unreachable from peripheral hub
// R16 - Control bit 0 activates debugging, resets 0
// R17 - Activate pauses the central periodic timer
// R18 - Control writes need key 1011 in 7:4
// R19 - Writing halt bit halts the CPU
// R20 - Step runs one instruction, then self-clears
// R21 - Step write effective only while halted
// R22 - Halt/step need permit and activate both
// R23 - Failed key window keeps GPIO till reset
module dpa_port_ctrl #(
  parameter int WIN_SHORT_CYC = dpa_pkg::DPA_WIN_SHORT_CYC,
  parameter int WIN_LONG_CYC = dpa_pkg::DPA_WIN_LONG_CYC
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic [1:0] i_port_select_latch,
  input wire logic i_std_io,
  input wire logic i_std_ck,
  input wire logic i_alt_io,
  input wire logic i_alt_ck,
  input wire logic i_single_wire_viewer_output,
  input wire logic i_cpu_permit_wr,
  input wire logic [7:0] i_cpu_permit_wdata,
  input wire logic i_tc_ctrl_wr,
  input wire logic [7:0] i_tc_ctrl_wdata,
  input wire logic i_cpu_step_done,
  output logic [1:0] o_port_mode,
  output logic o_pins_gpio,
  output logic o_std_io_out,
  output logic o_std_io_oe,
  output logic o_tdo_out,
  output logic o_tdo_oe,
  output logic o_jtag_tap_reset,
  output logic o_swd_line_reset,
  output logic o_acquired_alt,
  output logic [7:0] o_cpu_debug_permit,
  output logic [7:0] o_debug_control,
  output logic o_debug_access_ok,
  output logic o_cpu_halt,
  output logic o_cpu_step,
  output logic o_timer_pause
);
  import dpa_pkg::*;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [3:0] sy1_q, sy2_q;        // Two stages: std io/ck, alt io/ck
  logic sck_prev_q, ack_prev_q;    // Previous synchronised clock levels
  logic std_rise, alt_rise;        // Rising clock edges seen

  // Two flops on each pin before anything reads it
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sy1_q <= '0;
      sy2_q <= '0;
      sck_prev_q <= 1'b0;
      ack_prev_q <= 1'b0;
    end else if (i_ce) begin
      sy1_q <= {i_alt_ck, i_alt_io, i_std_ck, i_std_io};
      sy2_q <= sy1_q;
      sck_prev_q <= sy2_q[1];
      ack_prev_q <= sy2_q[3];
    end
  end

  assign std_rise = sy2_q[1] & ~sck_prev_q;
  assign alt_rise = sy2_q[3] & ~ack_prev_q;

  // ************************************************************
  // Link state machine
  // ************************************************************
  dpa_state_t st_q, st_d;          // Who owns the pins
  logic [1:0] mode_q, mode_d;      // Active configuration
  logic [14:0] win_q, win_d;       // Cycles since reset in key window
  logic [3:0] edg_q, edg_d;        // Clock edges counted in short window
  logic ext_q, ext_d;              // Window extended
  logic alt_q, alt_d;              // Acquired through alternate pair
  logic [45:0] sstd_q, sstd_d;     // Standard pair frame shifter
  logic [45:0] salt_q, salt_d;     // Alternate pair frame shifter
  logic [5:0] fcs_q, fcs_d;        // Bits left in standard-pair frame
  logic [5:0] fca_q, fca_d;        // Bits left in alternate-pair frame
  logic init_q, init_d;            // Reset-time latch capture pending
  logic tapr_q, tapr_d;            // TAP reset pulse
  logic swdr_q, swdr_d;            // SWD reset pulse
  logic hit_jtag, hit_swd;         // Changeover detector matches
  logic frame_std, frame_alt;      // Completed acquire frame per pair

  // A frame is the request, turnaround, OK ack, turnaround, key and parity
  function automatic logic frame_ok(input logic [45:0] s);
    frame_ok = s[7:0] == DPA_ACQ_REQ && s[11:9] == DPA_ACK_OK &&
               s[44:13] == DPA_ACQ_KEY && s[45] == 1'b0; // R6
  endfunction

  assign frame_std = fcs_q == 6'h1 && std_rise && frame_ok({sy2_q[0], sstd_q[45:1]});
  assign frame_alt = fca_q == 6'h1 && alt_rise && frame_ok({sy2_q[2], salt_q[45:1]});

  // Changeover to JTAG watches SWDIO on the standard pair only
  dpa_seq_det #(.RUN(DPA_HIGH_RUN), .PATTERN(DPA_SEQ_TO_JTAG)) u_to_jtag (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_clear(st_q != DPA_ST_SWD || alt_q),
    .i_bit_en(std_rise),
    .i_bit(sy2_q[0]),
    .o_hit(hit_jtag)
  );

  // Changeover to SWD watches TMS, which shares the SWDIO pin
  dpa_seq_det #(.RUN(DPA_HIGH_RUN), .PATTERN(DPA_SEQ_TO_SWD)) u_to_swd (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_clear(st_q != DPA_ST_JTAG),
    .i_bit_en(std_rise),
    .i_bit(sy2_q[0]),
    .o_hit(hit_swd)
  );

  // Next state of the link
  always_comb begin
    st_d = st_q;
    mode_d = mode_q;
    win_d = win_q;
    edg_d = edg_q;
    ext_d = ext_q;
    alt_d = alt_q;
    sstd_d = sstd_q;
    salt_d = salt_q;
    fcs_d = fcs_q;
    fca_d = fca_q;
    init_d = 1'b0;
    tapr_d = 1'b0;
    swdr_d = 1'b0;
    if (init_q) begin
      // Latch read once after reset release, never under reset itself
      mode_d = i_port_select_latch; // R1
      case (i_port_select_latch)
        DPA_SEL_SWD: st_d = DPA_ST_SWD; // R13
        DPA_SEL_OFF: st_d = DPA_ST_KEYWIN;
        default: st_d = DPA_ST_JTAG; // R13
      endcase
    end else begin
      case (st_q)
        DPA_ST_KEYWIN: begin
          // Shift both pairs; a frame starts at a high start bit
          if (std_rise) begin
            sstd_d = {sy2_q[0], sstd_q[45:1]};
            fcs_d = (fcs_q == 6'h0) ? (sy2_q[0] ? 6'(DPA_ACQ_BITS - 1) : 6'h0)
                                    : fcs_q - 6'h1;
          end
          if (alt_rise) begin
            salt_d = {sy2_q[2], salt_q[45:1]};
            fca_d = (fca_q == 6'h0) ? (sy2_q[2] ? 6'(DPA_ACQ_BITS - 1) : 6'h0)
                                    : fca_q - 6'h1;
          end
          if ((std_rise || alt_rise) && edg_q != 4'(DPA_EDGES_EXTEND))
            edg_d = edg_q + 4'h1;
          win_d = win_q + 15'h1;
          if (win_q < 15'(WIN_SHORT_CYC) && edg_d == 4'(DPA_EDGES_EXTEND))
            ext_d = 1'b1; // R4
          if (frame_std || frame_alt) begin
            // Idle SWD, ready for the next write
            st_d = DPA_ST_SWD; // R5
            mode_d = DPA_SEL_SWD; // R8
            alt_d = frame_alt && !frame_std;
          end else if (win_q >= 15'(ext_q ? WIN_LONG_CYC : WIN_SHORT_CYC) - 15'h1) begin
            st_d = DPA_ST_GPIO; // R3
          end
        end
        DPA_ST_SWD: begin
          if (hit_jtag) begin
            st_d = DPA_ST_JTAG; // R10
            mode_d = DPA_SEL_JTAG4;
            tapr_d = 1'b1;
          end
        end
        DPA_ST_JTAG: begin
          if (hit_swd) begin
            st_d = DPA_ST_SWD; // R11
            mode_d = DPA_SEL_SWD;
            alt_d = 1'b0;
            swdr_d = 1'b1;
          end
        end
        DPA_ST_GPIO: st_d = DPA_ST_GPIO; // R23
        default: st_d = DPA_ST_GPIO;
      endcase
    end
  end

  // Link registers
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st_q <= DPA_ST_GPIO;
      mode_q <= DPA_SEL_OFF;
      win_q <= '0;
      edg_q <= '0;
      ext_q <= 1'b0;
      alt_q <= 1'b0;
      sstd_q <= '0;
      salt_q <= '0;
      fcs_q <= '0;
      fca_q <= '0;
      init_q <= 1'b1;
      tapr_q <= 1'b0;
      swdr_q <= 1'b0;
    end else if (i_ce) begin
      st_q <= st_d;
      mode_q <= mode_d;
      win_q <= win_d;
      edg_q <= edg_d;
      ext_q <= ext_d;
      alt_q <= alt_d;
      sstd_q <= sstd_d;
      salt_q <= salt_d;
      fcs_q <= fcs_d;
      fca_q <= fca_d;
      init_q <= init_d;
      tapr_q <= tapr_d;
      swdr_q <= swdr_d;
    end
  end

  // ************************************************************
  // Debug unit gating and control register
  // ************************************************************
  logic [7:0] perm_q, perm_d;      // CPU-side permit register
  logic [7:0] ctl_q, ctl_d;        // Debug control register
  logic gate;                      // Permit and activate both set

  // Only the test controller port reaches the control register
  assign gate = perm_q[DPA_PERMIT_BIT] & ctl_q[DPA_CTL_ACT]; // R22

  always_comb begin
    perm_d = perm_q;
    ctl_d = ctl_q;
    if (i_cpu_permit_wr)
      perm_d = i_cpu_permit_wdata;
    // Hardware clear of step; a new step write in the same cycle wins
    if (i_cpu_step_done)
      ctl_d[DPA_CTL_STEP] = 1'b0; // R20
    // Write path exists only from the test controller, never the hub
    if (i_tc_ctrl_wr && perm_q[DPA_PERMIT_BIT] && st_q != DPA_ST_GPIO &&
        i_tc_ctrl_wdata[7:4] == DPA_CTL_KEY) begin // R14 R15 R18
      ctl_d[7:4] = DPA_CTL_KEY;
      ctl_d[3] = 1'b0;
      ctl_d[DPA_CTL_ACT] = i_tc_ctrl_wdata[DPA_CTL_ACT]; // R16
      if (gate) begin
        ctl_d[DPA_CTL_HALT] = i_tc_ctrl_wdata[DPA_CTL_HALT]; // R19
        if (ctl_q[DPA_CTL_HALT] && i_tc_ctrl_wdata[DPA_CTL_STEP])
          ctl_d[DPA_CTL_STEP] = 1'b1; // R21
      end
    end
    // Dropping permit or activate releases halt and step
    if (!perm_d[DPA_PERMIT_BIT] || !ctl_d[DPA_CTL_ACT]) begin
      ctl_d[DPA_CTL_HALT] = 1'b0;
      ctl_d[DPA_CTL_STEP] = 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      perm_q <= DPA_PERMIT_RESET;
      ctl_q <= DPA_CTL_RESET;
    end else if (i_ce) begin
      perm_q <= perm_d;
      ctl_q <= ctl_d;
    end
  end

  // ************************************************************
  // Registered outputs
  // ************************************************************
  logic ioe_q, tdo_q, toe_q, acc_q;

  // Viewer shares the TDO pin in every debug mode, not in GPIO
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tdo_q <= 1'b0;
      toe_q <= 1'b0;
      ioe_q <= 1'b0;
      acc_q <= 1'b0;
    end else if (i_ce) begin
      tdo_q <= i_single_wire_viewer_output; // R2
      toe_q <= st_d == DPA_ST_SWD || st_d == DPA_ST_JTAG; // R2
      ioe_q <= 1'b0;
      acc_q <= perm_d[DPA_PERMIT_BIT] && st_d != DPA_ST_GPIO &&
               st_d != DPA_ST_KEYWIN; // R14
    end
  end

  assign o_port_mode = mode_q;
  assign o_pins_gpio = st_q == DPA_ST_GPIO || st_q == DPA_ST_KEYWIN ? 1'b1 : 1'b0;
  assign o_std_io_out = 1'b0;
  assign o_std_io_oe = ioe_q;
  assign o_tdo_out = tdo_q;
  assign o_tdo_oe = toe_q;
  assign o_jtag_tap_reset = tapr_q;
  assign o_swd_line_reset = swdr_q;
  assign o_acquired_alt = alt_q; // R9
  assign o_cpu_debug_permit = perm_q;
  assign o_debug_control = ctl_q;
  assign o_debug_access_ok = acc_q;
  assign o_cpu_halt = ctl_q[DPA_CTL_HALT]; // R19
  assign o_cpu_step = ctl_q[DPA_CTL_STEP]; // R20
  assign o_timer_pause = ctl_q[DPA_CTL_ACT]; // R17
endmodule // dpa_port_ctrl
`default_nettype wire

// [sim/dpa_port_ctrl_checker.sv]
`timescale 1ns/100ps
`default_nettype none
// ********************
// Checker on the control and link outputs
// ********************
module dpa_port_ctrl_checker
  import dpa_pkg::*;
#(
  parameter int WIN_LONG_CYC = 16000
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_single_wire_viewer_output,
  input wire logic i_cpu_permit_wr,
  input wire logic i_tc_ctrl_wr,
  input wire logic [7:0] i_tc_ctrl_wdata,
  input wire logic i_cpu_step_done,
  input wire logic [1:0] o_port_mode,
  input wire logic o_pins_gpio,
  input wire logic o_tdo_out,
  input wire logic o_tdo_oe,
  input wire logic o_jtag_tap_reset,
  input wire logic o_swd_line_reset,
  input wire logic o_acquired_alt,
  input wire logic [7:0] o_cpu_debug_permit,
  input wire logic [7:0] o_debug_control,
  input wire logic o_debug_access_ok,
  input wire logic o_cpu_halt,
  input wire logic o_cpu_step,
  input wire logic o_timer_pause
);
  int cyc_q; // Cycles since reset, saturating
  // Margin covers synchroniser and frame decode latency
  localparam int LATE = WIN_LONG_CYC + 16;
  // Count register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset)
      cyc_q <= 0;
    else if (cyc_q <= LATE)
      cyc_q <= cyc_q + 1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  a_key_refused: assert property (i_ce && i_tc_ctrl_wr && i_tc_ctrl_wdata[7:4] != DPA_CTL_KEY
    && !i_cpu_step_done && !i_cpu_permit_wr |=> $stable(o_debug_control))
    else $error("keyless write landed");
  a_no_permit: assert property (i_tc_ctrl_wr && !o_cpu_debug_permit[0] && !i_cpu_step_done
    |=> $stable(o_debug_control))
    else $error("write without permit");
  a_act_written: assert property (i_ce && i_tc_ctrl_wr && i_tc_ctrl_wdata[7:4] == DPA_CTL_KEY
    && o_cpu_debug_permit[0] && o_port_mode != DPA_SEL_OFF && !i_cpu_permit_wr
    |=> o_debug_control[0] == $past(i_tc_ctrl_wdata[0]))
    else $error("activate bit not written");
  a_timer_pause: assert property (o_timer_pause == o_debug_control[DPA_CTL_ACT])
    else $error("pause not activate");
  a_halt_out: assert property (o_cpu_halt == o_debug_control[DPA_CTL_HALT])
    else $error("halt out wrong");
  a_step_halted: assert property ($rose(o_cpu_step) |-> $past(o_cpu_halt))
    else $error("step while running");
  a_halt_gate: assert property ($rose(o_cpu_halt) |-> $past(o_debug_control[0])
    && $past(o_cpu_debug_permit[0]))
    else $error("ungated halt");
  a_step_clear: assert property (i_ce && o_cpu_step && i_cpu_step_done && !i_tc_ctrl_wr
    |=> !o_cpu_step)
    else $error("step did not clear");
  a_tdo_viewer: assert property (o_tdo_oe && $past(i_ce)
    |-> o_tdo_out == $past(i_single_wire_viewer_output))
    else $error("tdo not viewer");
  a_gpio_quiet: assert property (o_pins_gpio |-> !o_tdo_oe && !o_debug_access_ok)
    else $error("gpio pins driven");
  a_tap_pulse: assert property (o_jtag_tap_reset
    |=> !o_jtag_tap_reset && o_port_mode == DPA_SEL_JTAG4)
    else $error("bad tap reset");
  a_swd_pulse: assert property (o_swd_line_reset
    |=> !o_swd_line_reset && o_port_mode == DPA_SEL_SWD)
    else $error("bad line reset");
  a_alt_no_jtag: assert property (o_acquired_alt |-> !o_jtag_tap_reset)
    else $error("jtag after alt acquire");
  a_late_key: assert property ($fell(o_pins_gpio) |-> cyc_q <= LATE)
    else $error("late acquire");
  a_gpio_kept: assert property (o_pins_gpio && cyc_q > LATE |=> o_pins_gpio)
    else $error("gpio lost");
endmodule // dpa_port_ctrl_checker
bind dpa_port_ctrl dpa_port_ctrl_checker #(.WIN_LONG_CYC(WIN_LONG_CYC)) dpa_port_ctrl_checker_inst (
  .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
  .i_single_wire_viewer_output(i_single_wire_viewer_output),
  .i_cpu_permit_wr(i_cpu_permit_wr), .i_tc_ctrl_wr(i_tc_ctrl_wr),
  .i_tc_ctrl_wdata(i_tc_ctrl_wdata), .i_cpu_step_done(i_cpu_step_done),
  .o_port_mode(o_port_mode), .o_pins_gpio(o_pins_gpio), .o_tdo_out(o_tdo_out),
  .o_tdo_oe(o_tdo_oe), .o_jtag_tap_reset(o_jtag_tap_reset),
  .o_swd_line_reset(o_swd_line_reset), .o_acquired_alt(o_acquired_alt),
  .o_cpu_debug_permit(o_cpu_debug_permit), .o_debug_control(o_debug_control),
  .o_debug_access_ok(o_debug_access_ok), .o_cpu_halt(o_cpu_halt),
  .o_cpu_step(o_cpu_step), .o_timer_pause(o_timer_pause)
);
`default_nettype wire

// [sim/dpa_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ********************
// Debug host on both pin pairs
// ********************
module dpa_host_model (
  input wire logic i_clk,
  output logic o_std_io,
  output logic o_std_ck,
  output logic o_alt_io,
  output logic o_alt_ck
);
  import dpa_pkg::*;
  logic [1:0] io_q = 2'h0; // Data lines, index 1 is the alternate pair
  logic [1:0] ck_q = 2'h0; // Link clocks, still between frames
  assign o_std_io = io_q[0];
  assign o_std_ck = ck_q[0];
  assign o_alt_io = io_q[1];
  assign o_alt_ck = ck_q[1];
  // One bit per 200 ns link period, taken on the rising edge
  task automatic send_bit(input int p, input logic b);
    @(posedge i_clk);
    io_q[p] <= b;
    ck_q[p] <= 1'b0;
    repeat (4) @(posedge i_clk);
    ck_q[p] <= 1'b1;
    repeat (3) @(posedge i_clk);
  endtask
  // Released line flips so no stale level can be mistaken for data
  task automatic release_pair(input int p);
    @(posedge i_clk);
    ck_q[p] <= 1'b0;
    io_q[p] <= ~io_q[p];
    repeat (8) @(posedge i_clk);
  endtask
  // Acquire frame; the ack slots carry OK as the line would
  task automatic send_acquire(input int p);
    logic [45:0] f;
    f = {1'b0, DPA_ACQ_KEY, 1'b1, DPA_ACK_OK, 1'b1, DPA_ACQ_REQ};
    repeat (2)
      for (int i = 0; i < 46; i++)
        send_bit(p, f[i]);
    release_pair(p);
  endtask
  // Long high run, then the changeover value LSB first
  task automatic send_change(input int p, input logic [15:0] v);
    repeat (DPA_HIGH_RUN)
      send_bit(p, 1'b1);
    for (int i = 0; i < 16; i++)
      send_bit(p, v[i]);
    release_pair(p);
  endtask
endmodule // dpa_host_model
`default_nettype wire

// [sim/debug_port_acquire_control_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module debug_port_acquire_control_bench;
  import dpa_pkg::*;
  localparam int WS = 320; // Short key window in cycles
  localparam int WL = 2000; // Long window, cut short for the run
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [1:0] sel = DPA_SEL_OFF; // Port-select latch
  logic single_wire_viewer_output = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pdata = 8'h00;
  logic cwr = 1'b0;
  logic [7:0] cdata = 8'h00;
  logic sdone = 1'b0;
  logic std_io, std_ck, alt_io, alt_ck;
  logic [1:0] mode;
  logic gpio, tdo, tdo_oe, tap_rst, swd_rst, alt_acq, acc_ok, halt, step, tpause;
  logic [7:0] permit, ctrl;
  logic tap_seen = 1'b0; // Pulses are one cycle, so latch them
  logic swd_seen = 1'b0;
  int failures = 0;
  int checks = 0;
  // ********************
  // Clock, design and host
  // ********************
  initial forever #12.5 i_clk = ~i_clk;
  dpa_port_ctrl #(.WIN_SHORT_CYC(WS), .WIN_LONG_CYC(WL)) dpa_port_ctrl_inst (
    .i_clk(i_clk), .i_reset(i_reset), .i_ce(1'b1), .i_port_select_latch(sel),
    .i_std_io(std_io), .i_std_ck(std_ck), .i_alt_io(alt_io), .i_alt_ck(alt_ck),
    .i_single_wire_viewer_output(single_wire_viewer_output), .i_cpu_permit_wr(pwr),
    .i_cpu_permit_wdata(pdata), .i_tc_ctrl_wr(cwr), .i_tc_ctrl_wdata(cdata),
    .i_cpu_step_done(sdone), .o_port_mode(mode), .o_pins_gpio(gpio),
    .o_std_io_out(), .o_std_io_oe(), .o_tdo_out(tdo), .o_tdo_oe(tdo_oe),
    .o_jtag_tap_reset(tap_rst), .o_swd_line_reset(swd_rst), .o_acquired_alt(alt_acq),
    .o_cpu_debug_permit(permit), .o_debug_control(ctrl), .o_debug_access_ok(acc_ok),
    .o_cpu_halt(halt), .o_cpu_step(step), .o_timer_pause(tpause));
  dpa_host_model dpa_host_model_inst (.i_clk(i_clk), .o_std_io(std_io),
    .o_std_ck(std_ck), .o_alt_io(alt_io), .o_alt_ck(alt_ck));
  // Catch the one-cycle changeover pulses
  always @(posedge i_clk) begin
    if (tap_rst === 1'b1) tap_seen <= 1'b1;
    if (swd_rst === 1'b1) swd_seen <= 1'b1;
  end
  // ********************
  // Shared tasks
  // ********************
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic do_reset(input logic [1:0] s);
    i_reset <= 1'b1;
    sel <= s;
    repeat (20) @(posedge i_clk);
    check("mode in reset", 8'(DPA_SEL_OFF), 8'(mode));
    i_reset <= 1'b0;
    tap_seen <= 1'b0;
    swd_seen <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
  task automatic ctrl_wr(input logic [7:0] v);
    cwr <= 1'b1;
    cdata <= v;
    @(posedge i_clk);
    cwr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ********************
  // Scenarios
  // ********************
  // Every latch code, reset values and viewer routing
  task automatic t_latch();
    for (int k = 0; k < 4; k++) begin
      do_reset(2'(k));
      check("mode", 8'(k), 8'(mode));
      check("gpio", 8'(k == 3), 8'(gpio));
      check("permit", DPA_PERMIT_RESET, permit);
      check("control", DPA_CTL_RESET, ctrl);
      single_wire_viewer_output <= 1'b1;
      repeat (2) @(posedge i_clk);
      check("tdo", 8'(k != 3), 8'(tdo & tdo_oe));
      single_wire_viewer_output <= 1'b0;
    end
  endtask
  // Frame outlasts the short window, so it needs the extension
  task automatic t_acq_std();
    do_reset(DPA_SEL_OFF);
    dpa_host_model_inst.send_acquire(0);
    check("acquire mode", 8'(DPA_SEL_SWD), 8'(mode));
    dpa_host_model_inst.send_change(0, DPA_SEQ_TO_JTAG);
    check("jtag mode", 8'(DPA_SEL_JTAG4), 8'(mode));
    check("tap reset", 8'h01, 8'(tap_seen));
    dpa_host_model_inst.send_change(0, DPA_SEQ_TO_SWD);
    check("swd mode", 8'(DPA_SEL_SWD), 8'(mode));
    check("line reset", 8'h01, 8'(swd_seen));
  endtask
  // Alternate pair acquires, but JTAG changeover is refused
  task automatic t_acq_alt();
    do_reset(DPA_SEL_OFF);
    dpa_host_model_inst.send_acquire(1);
    check("alt mode", 8'(DPA_SEL_SWD), 8'(mode));
    check("alt flag", 8'h01, 8'(alt_acq));
    dpa_host_model_inst.send_change(0, DPA_SEQ_TO_JTAG);
    check("alt no jtag", 8'(DPA_SEL_SWD), 8'(mode));
    check("alt no tap", 8'h00, 8'(tap_seen));
  endtask
  // Key after a quiet short window is refused
  task automatic t_window();
    do_reset(DPA_SEL_OFF);
    repeat (WS + 10) @(posedge i_clk);
    dpa_host_model_inst.send_acquire(0);
    check("late mode", 8'(DPA_SEL_OFF), 8'(mode));
    check("late gpio", 8'h01, 8'(gpio));
  endtask
  // Control register gating, with the latch selecting SWD
  task automatic t_ctrl();
    do_reset(DPA_SEL_SWD);
    ctrl_wr(8'hb1);
    check("no permit", 8'h00, ctrl);
    pwr <= 1'b1;
    pdata <= 8'h01;
    @(posedge i_clk);
    pwr <= 1'b0;
    @(posedge i_clk);
    check("permit", 8'h01, permit);
    check("access", 8'h01, 8'(acc_ok));
    ctrl_wr(8'ha1);
    check("bad key", 8'h00, ctrl);
    ctrl_wr(8'hb2);
    check("halt idle", 8'hb0, ctrl);
    ctrl_wr(8'hb1);
    check("activate", 8'hb1, ctrl);
    check("pause", 8'h01, 8'(tpause));
    ctrl_wr(8'hb7);
    check("halt", 8'hb3, ctrl);
    check("halt out", 8'h01, 8'(halt));
    ctrl_wr(8'hb7);
    check("step", 8'h01, 8'(step));
    sdone <= 1'b1;
    @(posedge i_clk);
    sdone <= 1'b0;
    @(posedge i_clk);
    check("step done", 8'hb3, ctrl);
    ctrl_wr(8'hb0);
    check("deactivate", 8'hb0, ctrl);
    check("unpause", 8'h00, 8'(tpause));
  endtask
  initial begin
    t_latch();
    t_acq_std();
    t_acq_alt();
    t_window();
    t_ctrl();
    test_done();
  end
  // Tests need about 4400 cycles
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    test_done();
  end
endmodule // debug_port_acquire_control_bench
`default_nettype wire
